// >>> pkg/aabe_pkg.sv
// constants, op codes and state type for the alu and branch execution block
package aabe_pkg;

	// ----------------------------------------------------------------
	// register byte offsets on the ahb-lite bus
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_OFFSET = 8'h04;
	localparam logic [7:0] ADDR_PC = 8'h08;
	localparam logic [7:0] ADDR_SP = 8'h0C;
	localparam logic [7:0] ADDR_FLAGS = 8'h10;
	localparam logic [7:0] ADDR_IO = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_RET = 8'h1C;
	localparam int unsigned ADDR_RF_BIT = 7;

	// ----------------------------------------------------------------
	// command word fields
	// ----------------------------------------------------------------
	localparam int unsigned CMD_WIDTH = 25;
	localparam int unsigned CMD_OP_LSB = 0;
	localparam int unsigned CMD_DST_LSB = 6;
	localparam int unsigned CMD_SRC_LSB = 11;
	localparam int unsigned CMD_K_LSB = 16;
	localparam int unsigned CMD_TWO_WORD_BIT = 24;

	// ----------------------------------------------------------------
	// status word fields
	// ----------------------------------------------------------------
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_JUMP_BIT = 1;
	localparam int unsigned STAT_BAD_BIT = 2;
	localparam int unsigned STAT_CYC_LSB = 4;

	// ----------------------------------------------------------------
	// flag register bit positions
	// ----------------------------------------------------------------
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_N = 2;
	localparam int unsigned FLAG_V = 3;
	localparam int unsigned FLAG_S = 4;
	localparam int unsigned FLAG_H = 5;

	// ----------------------------------------------------------------
	// reset values, steps and fixed register indices
	// ----------------------------------------------------------------
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] SP_RESET = 16'h00FF;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [15:0] PC_STEP = 16'h0001;
	localparam logic [15:0] PC_SKIP_ONE = 16'h0002;
	localparam logic [15:0] PC_SKIP_TWO = 16'h0003;
	localparam logic [15:0] STACK_STEP = 16'h0002;
	localparam logic [4:0] IDX_PRODUCT = 5'h00;
	localparam logic [4:0] IDX_POINTER_Z = 5'h1E;
	localparam logic [2:0] SIZE_WORD = 3'h2;

	// ----------------------------------------------------------------
	// cycle counts
	// ----------------------------------------------------------------
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;

	// ----------------------------------------------------------------
	// operation codes
	// ----------------------------------------------------------------
	localparam logic [5:0] OP_ADD = 6'h00;
	localparam logic [5:0] OP_ADD_CARRY = 6'h01;
	localparam logic [5:0] OP_WORD_ADD_IMMEDIATE = 6'h02;
	localparam logic [5:0] OP_SUB = 6'h03;
	localparam logic [5:0] OP_SUBTRACT_IMMEDIATE = 6'h04;
	localparam logic [5:0] OP_SUBTRACT_WITH_BORROW = 6'h05;
	localparam logic [5:0] OP_SUBTRACT_BORROW_IMMEDIATE = 6'h06;
	localparam logic [5:0] OP_WORD_SUBTRACT_IMMEDIATE = 6'h07;
	localparam logic [5:0] OP_AND = 6'h08;
	localparam logic [5:0] OP_AND_IMMEDIATE = 6'h09;
	localparam logic [5:0] OP_OR = 6'h0A;
	localparam logic [5:0] OP_OR_IMMEDIATE = 6'h0B;
	localparam logic [5:0] OP_EXCLUSIVE_OR_REGS = 6'h0C;
	localparam logic [5:0] OP_BITWISE_INVERT = 6'h0D;
	localparam logic [5:0] OP_SIGN_FLIP = 6'h0E;
	localparam logic [5:0] OP_SET_BITS_MASK = 6'h0F;
	localparam logic [5:0] OP_CLEAR_BITS_MASK = 6'h10;
	localparam logic [5:0] OP_TEST_ZERO_MINUS = 6'h11;
	localparam logic [5:0] OP_ZERO_REGISTER = 6'h12;
	localparam logic [5:0] OP_ALL_ONES_REGISTER = 6'h13;
	localparam logic [5:0] OP_UNSIGNED_PRODUCT = 6'h14;
	localparam logic [5:0] OP_SIGNED_PRODUCT = 6'h15;
	localparam logic [5:0] OP_MIXED_SIGN_PRODUCT = 6'h16;
	localparam logic [5:0] OP_FRACTION_PRODUCT_UNSIGNED = 6'h17;
	localparam logic [5:0] OP_FRACTION_PRODUCT_SIGNED = 6'h18;
	localparam logic [5:0] OP_FRACTION_PRODUCT_MIXED = 6'h19;
	localparam logic [5:0] OP_RELATIVE_JUMP = 6'h1A;
	localparam logic [5:0] OP_INDIRECT_JUMP = 6'h1B;
	localparam logic [5:0] OP_RELATIVE_CALL = 6'h1C;
	localparam logic [5:0] OP_INDIRECT_CALL = 6'h1D;
	localparam logic [5:0] OP_COMPARE_SKIP_EQUAL = 6'h1E;
	localparam logic [5:0] OP_COMPARE = 6'h1F;
	localparam logic [5:0] OP_COMPARE_WITH_CARRY = 6'h20;
	localparam logic [5:0] OP_COMPARE_IMMEDIATE = 6'h21;
	localparam logic [5:0] OP_SKIP_REG_BIT_CLEAR = 6'h22;
	localparam logic [5:0] OP_SKIP_REG_BIT_SET = 6'h23;
	localparam logic [5:0] OP_SKIP_IO_BIT_CLEAR = 6'h24;
	localparam logic [5:0] OP_SKIP_IO_BIT_SET = 6'h25;
	localparam logic [5:0] OP_BRANCH_FLAG_SET = 6'h26;

	typedef enum logic [1:0] {AABE_ST_IDLE, AABE_ST_EXEC, AABE_ST_HOLD} aabe_state_t;

endpackage : aabe_pkg

// >>> verilog/aabe_top.sv
// alu, multiply, jump, call and skip execution unit behind an ahb-lite slave
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps

module aabe_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] rf_r [0:31];
	logic [aabe_pkg::CMD_WIDTH-1:0] cmd_r, cmd_nxt;
	logic [15:0] off_r, off_nxt;
	logic [15:0] pc_r, pc_nxt;
	logic [15:0] sp_r, sp_nxt;
	logic [15:0] ret_r, ret_nxt;
	logic [7:0] flags_r, flags_nxt;
	logic [7:0] io_r, io_nxt;
	logic jump_r, jump_nxt;
	logic bad_r, bad_nxt;
	logic [1:0] cyc_r, cyc_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	aabe_pkg::aabe_state_t state_r, state_nxt;
	logic wr_r, wr_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic hreadyout_r;
	logic hresp_r;

	// register file write ports: lane a (bus, single-byte result or low byte), lane b (high byte)
	logic we_a, we_b;
	logic [4:0] idx_a, idx_b;
	logic [7:0] dat_a, dat_b;

	// ----------------------------------------------------------------
	// command decode and operands
	// ----------------------------------------------------------------
	logic [5:0] op;
	logic [4:0] dst, src, lo_idx, hi_idx;
	logic [7:0] k, a_val, b_val, r_val;
	logic two_word, imm_sel, carry_sel, chain_z, cin;
	logic [8:0] sum9, dif9;
	logic [15:0] word_val, word_sum, word_dif, prod16, frac16;
	logic signed [8:0] ma, mb;
	logic signed [17:0] prod;
	logic sa, sb;

	assign op = cmd_r[aabe_pkg::CMD_OP_LSB +: 6];
	assign dst = cmd_r[aabe_pkg::CMD_DST_LSB +: 5];
	assign src = cmd_r[aabe_pkg::CMD_SRC_LSB +: 5];
	assign k = cmd_r[aabe_pkg::CMD_K_LSB +: 8];
	assign two_word = cmd_r[aabe_pkg::CMD_TWO_WORD_BIT];
	assign lo_idx = {dst[4:1], 1'h0};
	assign hi_idx = {dst[4:1], 1'h1};
	assign a_val = rf_r[dst];
	assign imm_sel = (op == aabe_pkg::OP_SUBTRACT_IMMEDIATE) || (op == aabe_pkg::OP_SUBTRACT_BORROW_IMMEDIATE)
		|| (op == aabe_pkg::OP_AND_IMMEDIATE) || (op == aabe_pkg::OP_OR_IMMEDIATE)
		|| (op == aabe_pkg::OP_SET_BITS_MASK) || (op == aabe_pkg::OP_COMPARE_IMMEDIATE);
	assign chain_z = (op == aabe_pkg::OP_SUBTRACT_WITH_BORROW) || (op == aabe_pkg::OP_SUBTRACT_BORROW_IMMEDIATE)
		|| (op == aabe_pkg::OP_COMPARE_WITH_CARRY);
	assign carry_sel = chain_z || (op == aabe_pkg::OP_ADD_CARRY);
	assign b_val = imm_sel ? k : rf_r[src];
	assign cin = carry_sel & flags_r[aabe_pkg::FLAG_C];
	assign sum9 = {1'h0, a_val} + {1'h0, b_val} + {8'h00, cin};
	assign dif9 = {1'h0, a_val} - {1'h0, b_val} - {8'h00, cin};
	assign word_val = {rf_r[hi_idx], rf_r[lo_idx]};
	assign word_sum = word_val + {10'h000, k[5:0]};
	assign word_dif = word_val - {10'h000, k[5:0]};
	assign sa = (op == aabe_pkg::OP_SIGNED_PRODUCT) || (op == aabe_pkg::OP_MIXED_SIGN_PRODUCT)
		|| (op == aabe_pkg::OP_FRACTION_PRODUCT_SIGNED) || (op == aabe_pkg::OP_FRACTION_PRODUCT_MIXED);
	assign sb = (op == aabe_pkg::OP_SIGNED_PRODUCT) || (op == aabe_pkg::OP_FRACTION_PRODUCT_SIGNED);
	assign ma = {sa & a_val[7], a_val};
	assign mb = {sb & b_val[7], b_val};
	assign prod = ma * mb;
	assign prod16 = prod[15:0];
	assign frac16 = {prod16[14:0], 1'h0};

	// ----------------------------------------------------------------
	// flag helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] add_fl(input logic [7:0] x, input logic [7:0] y, input logic [7:0] r,
		input logic [7:0] f);
		logic [7:0] o;
		o = f;
		o[aabe_pkg::FLAG_H] = (x[3] & y[3]) | (y[3] & ~r[3]) | (~r[3] & x[3]);
		o[aabe_pkg::FLAG_V] = (x[7] & y[7] & ~r[7]) | (~x[7] & ~y[7] & r[7]);
		o[aabe_pkg::FLAG_C] = (x[7] & y[7]) | (y[7] & ~r[7]) | (~r[7] & x[7]);
		o[aabe_pkg::FLAG_N] = r[7];
		o[aabe_pkg::FLAG_Z] = (r == 8'h00);
		return o;
	endfunction : add_fl

	// with carry-in the zero flag only stays set, so multi-byte compares chain
	function automatic logic [7:0] sub_fl(input logic [7:0] x, input logic [7:0] y, input logic [7:0] r,
		input logic [7:0] f, input logic chain);
		logic [7:0] o;
		o = f;
		o[aabe_pkg::FLAG_H] = (~x[3] & y[3]) | (y[3] & r[3]) | (r[3] & ~x[3]);
		o[aabe_pkg::FLAG_V] = (x[7] & ~y[7] & ~r[7]) | (~x[7] & y[7] & r[7]);
		o[aabe_pkg::FLAG_C] = (~x[7] & y[7]) | (y[7] & r[7]) | (r[7] & ~x[7]);
		o[aabe_pkg::FLAG_N] = r[7];
		o[aabe_pkg::FLAG_Z] = (r == 8'h00) & (~chain | f[aabe_pkg::FLAG_Z]);
		return o;
	endfunction : sub_fl

	function automatic logic [7:0] logic_fl(input logic [7:0] r, input logic [7:0] f);
		logic [7:0] o;
		o = f;
		o[aabe_pkg::FLAG_V] = 1'h0;
		o[aabe_pkg::FLAG_N] = r[7];
		o[aabe_pkg::FLAG_Z] = (r == 8'h00);
		return o;
	endfunction : logic_fl

	// ----------------------------------------------------------------
	// execution results
	// ----------------------------------------------------------------
	logic x_wr, x_pair, x_push, x_jump, x_bad, skip_hit;
	logic [7:0] x_res, x_fl;
	logic [4:0] x_pair_lo;
	logic [15:0] x_pair_val, x_pc;
	logic [1:0] x_cyc;

	always_comb begin : exec_calc
		x_wr = 1'h0;
		x_res = a_val;
		x_pair = 1'h0;
		x_pair_lo = lo_idx;
		x_pair_val = 16'h0000;
		x_fl = flags_r;
		x_pc = pc_r + aabe_pkg::PC_STEP;
		x_cyc = aabe_pkg::CYC_ONE;
		x_push = 1'h0;
		x_jump = 1'h0;
		x_bad = 1'h0;
		skip_hit = 1'h0;
		r_val = 8'h00;
		case (op)
			aabe_pkg::OP_ADD, aabe_pkg::OP_ADD_CARRY: begin
				x_wr = 1'h1;
				x_res = sum9[7:0];
				x_fl = add_fl(a_val, b_val, sum9[7:0], flags_r);
			end
			aabe_pkg::OP_SUB, aabe_pkg::OP_SUBTRACT_IMMEDIATE, aabe_pkg::OP_SUBTRACT_WITH_BORROW,
			aabe_pkg::OP_SUBTRACT_BORROW_IMMEDIATE: begin
				x_wr = 1'h1;
				x_res = dif9[7:0];
				x_fl = sub_fl(a_val, b_val, dif9[7:0], flags_r, chain_z);
			end
			aabe_pkg::OP_WORD_ADD_IMMEDIATE, aabe_pkg::OP_WORD_SUBTRACT_IMMEDIATE: begin
				x_pair = 1'h1;
				x_cyc = aabe_pkg::CYC_TWO;
				x_pair_val = (op == aabe_pkg::OP_WORD_ADD_IMMEDIATE) ? word_sum : word_dif;
				x_fl[aabe_pkg::FLAG_N] = x_pair_val[15];
				x_fl[aabe_pkg::FLAG_Z] = (x_pair_val == 16'h0000);
				if (op == aabe_pkg::OP_WORD_ADD_IMMEDIATE) begin
					x_fl[aabe_pkg::FLAG_V] = ~word_val[15] & x_pair_val[15];
					x_fl[aabe_pkg::FLAG_C] = word_val[15] & ~x_pair_val[15];
				end else begin
					x_fl[aabe_pkg::FLAG_V] = word_val[15] & ~x_pair_val[15];
					x_fl[aabe_pkg::FLAG_C] = ~word_val[15] & x_pair_val[15];
				end
				x_fl[aabe_pkg::FLAG_S] = x_fl[aabe_pkg::FLAG_N] ^ x_fl[aabe_pkg::FLAG_V];
			end
			aabe_pkg::OP_AND, aabe_pkg::OP_AND_IMMEDIATE, aabe_pkg::OP_TEST_ZERO_MINUS: begin
				r_val = a_val & ((op == aabe_pkg::OP_TEST_ZERO_MINUS) ? a_val : b_val);
				x_wr = (op != aabe_pkg::OP_TEST_ZERO_MINUS);
				x_res = r_val;
				x_fl = logic_fl(r_val, flags_r);
			end
			aabe_pkg::OP_OR, aabe_pkg::OP_OR_IMMEDIATE, aabe_pkg::OP_SET_BITS_MASK: begin
				r_val = a_val | b_val;
				x_wr = 1'h1;
				x_res = r_val;
				x_fl = logic_fl(r_val, flags_r);
			end
			aabe_pkg::OP_CLEAR_BITS_MASK: begin
				r_val = a_val & (8'hFF - k);
				x_wr = 1'h1;
				x_res = r_val;
				x_fl = logic_fl(r_val, flags_r);
			end
			aabe_pkg::OP_EXCLUSIVE_OR_REGS, aabe_pkg::OP_ZERO_REGISTER: begin
				r_val = a_val ^ ((op == aabe_pkg::OP_ZERO_REGISTER) ? a_val : b_val);
				x_wr = 1'h1;
				x_res = r_val;
				x_fl = logic_fl(r_val, flags_r);
			end
			aabe_pkg::OP_ALL_ONES_REGISTER: begin
				x_wr = 1'h1;
				x_res = 8'hFF;
			end
			aabe_pkg::OP_BITWISE_INVERT: begin
				r_val = 8'hFF - a_val;
				x_wr = 1'h1;
				x_res = r_val;
				x_fl = logic_fl(r_val, flags_r);
				x_fl[aabe_pkg::FLAG_C] = 1'h1;
			end
			aabe_pkg::OP_SIGN_FLIP: begin
				r_val = 8'h00 - a_val;
				x_wr = 1'h1;
				x_res = r_val;
				x_fl = logic_fl(r_val, flags_r);
				x_fl[aabe_pkg::FLAG_C] = (r_val != 8'h00);
				x_fl[aabe_pkg::FLAG_V] = (r_val == 8'h80);
				x_fl[aabe_pkg::FLAG_H] = r_val[3] | a_val[3];
			end
			aabe_pkg::OP_UNSIGNED_PRODUCT, aabe_pkg::OP_SIGNED_PRODUCT, aabe_pkg::OP_MIXED_SIGN_PRODUCT: begin
				x_pair = 1'h1;
				x_pair_lo = aabe_pkg::IDX_PRODUCT;
				x_pair_val = prod16;
				x_cyc = aabe_pkg::CYC_TWO;
				x_fl[aabe_pkg::FLAG_C] = prod16[15];
				x_fl[aabe_pkg::FLAG_Z] = (prod16 == 16'h0000);
			end
			aabe_pkg::OP_FRACTION_PRODUCT_UNSIGNED, aabe_pkg::OP_FRACTION_PRODUCT_SIGNED,
			aabe_pkg::OP_FRACTION_PRODUCT_MIXED: begin
				x_pair = 1'h1;
				x_pair_lo = aabe_pkg::IDX_PRODUCT;
				x_pair_val = frac16;
				x_cyc = aabe_pkg::CYC_TWO;
				x_fl[aabe_pkg::FLAG_C] = prod16[15];
				x_fl[aabe_pkg::FLAG_Z] = (frac16 == 16'h0000);
			end
			aabe_pkg::OP_RELATIVE_JUMP, aabe_pkg::OP_RELATIVE_CALL: begin
				x_pc = pc_r + off_r + aabe_pkg::PC_STEP;
				x_jump = 1'h1;
				x_push = (op == aabe_pkg::OP_RELATIVE_CALL);
				x_cyc = x_push ? aabe_pkg::CYC_THREE : aabe_pkg::CYC_TWO;
			end
			aabe_pkg::OP_INDIRECT_JUMP, aabe_pkg::OP_INDIRECT_CALL: begin
				x_pc = {rf_r[aabe_pkg::IDX_POINTER_Z + 5'h01], rf_r[aabe_pkg::IDX_POINTER_Z]};
				x_jump = 1'h1;
				x_push = (op == aabe_pkg::OP_INDIRECT_CALL);
				x_cyc = x_push ? aabe_pkg::CYC_THREE : aabe_pkg::CYC_TWO;
			end
			aabe_pkg::OP_COMPARE_SKIP_EQUAL: begin
				skip_hit = (a_val == b_val);
			end
			aabe_pkg::OP_COMPARE, aabe_pkg::OP_COMPARE_WITH_CARRY, aabe_pkg::OP_COMPARE_IMMEDIATE: begin
				x_fl = sub_fl(a_val, b_val, dif9[7:0], flags_r, chain_z);
			end
			aabe_pkg::OP_SKIP_REG_BIT_CLEAR, aabe_pkg::OP_SKIP_REG_BIT_SET: begin
				skip_hit = (a_val[k[2:0]] == (op == aabe_pkg::OP_SKIP_REG_BIT_SET));
			end
			aabe_pkg::OP_SKIP_IO_BIT_CLEAR, aabe_pkg::OP_SKIP_IO_BIT_SET: begin
				skip_hit = (io_r[k[2:0]] == (op == aabe_pkg::OP_SKIP_IO_BIT_SET));
			end
			aabe_pkg::OP_BRANCH_FLAG_SET: begin
				if (flags_r[k[2:0]]) begin
					x_pc = pc_r + off_r + aabe_pkg::PC_STEP;
					x_jump = 1'h1;
					x_cyc = aabe_pkg::CYC_TWO;
				end
			end
			default: begin
				x_bad = 1'h1;
			end
		endcase
		if (skip_hit) begin
			x_jump = 1'h1;
			x_pc = pc_r + (two_word ? aabe_pkg::PC_SKIP_TWO : aabe_pkg::PC_SKIP_ONE);
			x_cyc = two_word ? aabe_pkg::CYC_THREE : aabe_pkg::CYC_TWO;
		end
	end

	// ----------------------------------------------------------------
	// core state: command, operands, results and sequencing
	// ----------------------------------------------------------------
	always_comb begin : core_next
		cmd_nxt = cmd_r;
		off_nxt = off_r;
		pc_nxt = pc_r;
		sp_nxt = sp_r;
		ret_nxt = ret_r;
		flags_nxt = flags_r;
		io_nxt = io_r;
		jump_nxt = jump_r;
		bad_nxt = bad_r;
		cyc_nxt = cyc_r;
		cnt_nxt = cnt_r;
		state_nxt = state_r;
		we_a = 1'h0;
		we_b = 1'h0;
		idx_a = addr_r[6:2];
		idx_b = hi_idx;
		dat_a = hwdata[7:0];
		dat_b = 8'h00;
		unique case (state_r)
			aabe_pkg::AABE_ST_IDLE: begin
				// bus writes land only while idle
				if (wr_r) begin
					if (addr_r[aabe_pkg::ADDR_RF_BIT]) begin
						we_a = 1'h1;
					end else begin
						case (addr_r)
							aabe_pkg::ADDR_CMD: begin
								cmd_nxt = hwdata[aabe_pkg::CMD_WIDTH-1:0];
								state_nxt = aabe_pkg::AABE_ST_EXEC;
							end
							aabe_pkg::ADDR_OFFSET: off_nxt = hwdata[15:0];
							aabe_pkg::ADDR_PC: pc_nxt = hwdata[15:0];
							aabe_pkg::ADDR_SP: sp_nxt = hwdata[15:0];
							aabe_pkg::ADDR_FLAGS: flags_nxt = hwdata[7:0];
							aabe_pkg::ADDR_IO: io_nxt = hwdata[7:0];
							default: ;
						endcase
					end
				end
			end
			aabe_pkg::AABE_ST_EXEC: begin
				if (x_pair) begin
					we_a = 1'h1;
					idx_a = x_pair_lo;
					dat_a = x_pair_val[7:0];
					we_b = 1'h1;
					idx_b = x_pair_lo | 5'h01;
					dat_b = x_pair_val[15:8];
				end else if (x_wr) begin
					we_a = 1'h1;
					idx_a = dst;
					dat_a = x_res;
				end
				flags_nxt = x_fl;
				pc_nxt = x_pc;
				if (x_push) begin
					ret_nxt = pc_r + aabe_pkg::PC_STEP;
					sp_nxt = sp_r - aabe_pkg::STACK_STEP;
				end
				jump_nxt = x_jump;
				bad_nxt = x_bad;
				cyc_nxt = x_cyc;
				cnt_nxt = x_cyc - aabe_pkg::CYC_TWO;
				state_nxt = (x_cyc == aabe_pkg::CYC_ONE) ? aabe_pkg::AABE_ST_IDLE : aabe_pkg::AABE_ST_HOLD;
			end
			aabe_pkg::AABE_ST_HOLD: begin
				// multi-cycle operations keep the unit busy for their full count
				if (cnt_r == 2'h0) begin
					state_nxt = aabe_pkg::AABE_ST_IDLE;
				end else begin
					cnt_nxt = cnt_r - 2'h1;
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_r <= '0;
			off_r <= 16'h0000;
			pc_r <= aabe_pkg::PC_RESET;
			sp_r <= aabe_pkg::SP_RESET;
			ret_r <= 16'h0000;
			flags_r <= aabe_pkg::FLAGS_RESET;
			io_r <= 8'h00;
			jump_r <= 1'h0;
			bad_r <= 1'h0;
			cyc_r <= 2'h0;
			cnt_r <= 2'h0;
			state_r <= aabe_pkg::AABE_ST_IDLE;
			for (int i = 0; i < 32; i++) begin
				rf_r[i] <= 8'h00;
			end
		end else begin
			cmd_r <= cmd_nxt;
			off_r <= off_nxt;
			pc_r <= pc_nxt;
			sp_r <= sp_nxt;
			ret_r <= ret_nxt;
			flags_r <= flags_nxt;
			io_r <= io_nxt;
			jump_r <= jump_nxt;
			bad_r <= bad_nxt;
			cyc_r <= cyc_nxt;
			cnt_r <= cnt_nxt;
			state_r <= state_nxt;
			if (we_a) begin
				rf_r[idx_a] <= dat_a;
			end
			if (we_b) begin
				rf_r[idx_b] <= dat_b;
			end
		end
	end

	// ----------------------------------------------------------------
	// ahb-lite slave: zero wait state, read data registered at address phase
	// ----------------------------------------------------------------
	logic addr_phase;
	logic [31:0] status_word;

	assign addr_phase = hsel & htrans[1] & hready;

	always_comb begin : bus_next
		status_word = 32'h00000000;
		status_word[aabe_pkg::STAT_BUSY_BIT] = (state_r != aabe_pkg::AABE_ST_IDLE);
		status_word[aabe_pkg::STAT_JUMP_BIT] = jump_r;
		status_word[aabe_pkg::STAT_BAD_BIT] = bad_r;
		status_word[aabe_pkg::STAT_CYC_LSB +: 2] = cyc_r;
		wr_nxt = addr_phase & hwrite & (hsize == aabe_pkg::SIZE_WORD);
		addr_nxt = addr_phase ? haddr[7:0] : addr_r;
		hrdata_nxt = 32'h00000000;
		if (addr_phase && !hwrite) begin
			if (haddr[aabe_pkg::ADDR_RF_BIT]) begin
				hrdata_nxt = {24'h000000, rf_r[haddr[6:2]]};
			end else begin
				case (haddr[7:0])
					aabe_pkg::ADDR_CMD: hrdata_nxt = {7'h00, cmd_r};
					aabe_pkg::ADDR_OFFSET: hrdata_nxt = {16'h0000, off_r};
					aabe_pkg::ADDR_PC: hrdata_nxt = {16'h0000, pc_r};
					aabe_pkg::ADDR_SP: hrdata_nxt = {16'h0000, sp_r};
					aabe_pkg::ADDR_FLAGS: hrdata_nxt = {24'h000000, flags_r};
					aabe_pkg::ADDR_IO: hrdata_nxt = {24'h000000, io_r};
					aabe_pkg::ADDR_STATUS: hrdata_nxt = status_word;
					aabe_pkg::ADDR_RET: hrdata_nxt = {16'h0000, ret_r};
					default: hrdata_nxt = 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_r <= 1'h0;
			addr_r <= 8'h00;
			hrdata_r <= 32'h00000000;
			hreadyout_r <= 1'h1;
			hresp_r <= 1'h0;
		end else begin
			wr_r <= wr_nxt;
			addr_r <= addr_nxt;
			hrdata_r <= hrdata_nxt;
			hreadyout_r <= 1'h1;
			hresp_r <= 1'h0;
		end
	end

	assign hrdata = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp = hresp_r;

endmodule : aabe_top

// >>> tb/aabe_host.sv
// bus master model for single word transfers
`timescale 1ns/1ps
module aabe_host (
	input wire logic hclk,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	output logic hsel = 1'h0,
	output logic [31:0] haddr = 32'h0,
	output logic [1:0] htrans = 2'h0,
	output logic hwrite = 1'h0,
	output logic [31:0] hwdata = 32'h0
);
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		q = hrdata;
		// released data lines show the inverse
		hwdata <= ~d;
	endtask : xfer
endmodule : aabe_host

// >>> tb/aabe_checker.sv
// port checker for the execution block
`timescale 1ns/1ps
module aabe_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence go;
		hsel && htrans[1] && hready;
	endsequence
	sequence rd_at(a);
		go and (!hwrite && haddr[7:0] == a);
	endsequence
	rdy_high_a: assert property (hreadyout)
		else $error("wait state");
	resp_okay_a: assert property (!hresp)
		else $error("error response");
	idle_zero_a: assert property (!(hsel && htrans[1] && hready) |=> hrdata == 32'h0)
		else $error("idle data");
	write_zero_a: assert property (go and hwrite |=> hrdata == 32'h0)
		else $error("write data");
	gap_zero_a: assert property (rd_at(8'h20) |=> hrdata == 32'h0)
		else $error("unmapped data");
	pc_width_a: assert property (rd_at(aabe_pkg::ADDR_PC) |=> hrdata[31:16] == 16'h0)
		else $error("pc width");
	flag_width_a: assert property (rd_at(aabe_pkg::ADDR_FLAGS) |=> hrdata[31:8] == 24'h0)
		else $error("flag width");
	ret_width_a: assert property (rd_at(aabe_pkg::ADDR_RET) |=> hrdata[31:16] == 16'h0)
		else $error("ret width");
endmodule : aabe_checker

bind aabe_top aabe_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// >>> tb/tb_top.sv
// self-checking bench for the execution block
`timescale 1ns/1ps
module tb_top;
	logic hclk = 1'h0;
	logic hresetn = 1'h0;
	logic hsel, hwrite, hreadyout, hresp;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, q;
	int errors = 0;
	int compares = 0;
	initial forever #5 hclk = ~hclk;
	aabe_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(aabe_pkg::SIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
	aabe_host u_host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(1'h1, a, d, q);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		u_host.xfer(1'h0, a, 32'h0, q);
		chk(q, e);
	endtask : rd
	function automatic logic [7:0] rf(input logic [4:0] n);
		return {1'h1, n, 2'h0};
	endfunction : rf
	task run(input logic [5:0] op, input logic [4:0] r, input logic [7:0] k, input logic two);
		wr(aabe_pkg::ADDR_CMD, {7'h0, two, k, r, r + 5'h1, op});
		do u_host.xfer(1'h0, aabe_pkg::ADDR_STATUS, 32'h0, q); while (q[0] !== 1'h0);
	endtask : run
	task t_arith;
		rd(aabe_pkg::ADDR_SP, 32'hFF);
		rd(8'h20, 32'h0);
		wr(rf(3), 32'h0F);
		wr(rf(2), 32'h01);
		run(aabe_pkg::OP_ADD, 5'h2, 8'h0, 1'h0);
		rd(rf(3), 32'h10);
		rd(aabe_pkg::ADDR_FLAGS, 32'h20);
		rd(aabe_pkg::ADDR_STATUS, 32'h10);
		wr(rf(5), 32'hFF);
		wr(rf(4), 32'hFF);
		run(aabe_pkg::OP_UNSIGNED_PRODUCT, 5'h4, 8'h0, 1'h0);
		rd(rf(0), 32'h01);
		rd(rf(1), 32'hFE);
		rd(aabe_pkg::ADDR_FLAGS, 32'h21);
		rd(aabe_pkg::ADDR_STATUS, 32'h20);
		$display("arith test done");
	endtask : t_arith
	task t_flow;
		wr(aabe_pkg::ADDR_OFFSET, 32'h10);
		run(aabe_pkg::OP_RELATIVE_CALL, 5'h0, 8'h0, 1'h0);
		rd(aabe_pkg::ADDR_PC, 32'h13);
		rd(aabe_pkg::ADDR_RET, 32'h03);
		rd(aabe_pkg::ADDR_SP, 32'hFD);
		run(aabe_pkg::OP_SKIP_REG_BIT_SET, 5'h2, 8'h04, 1'h1);
		rd(aabe_pkg::ADDR_PC, 32'h16);
		rd(aabe_pkg::ADDR_STATUS, 32'h32);
		run(aabe_pkg::OP_SKIP_REG_BIT_CLEAR, 5'h2, 8'h04, 1'h1);
		rd(aabe_pkg::ADDR_PC, 32'h17);
		rd(aabe_pkg::ADDR_STATUS, 32'h10);
		rd(aabe_pkg::ADDR_FLAGS, 32'h21);
		$display("flow test done");
	endtask : t_flow
	task t_ops;
		wr(aabe_pkg::ADDR_FLAGS, 32'h0);
		run(aabe_pkg::OP_SUBTRACT_IMMEDIATE, 5'h2, 8'h01, 1'h0);
		rd(rf(3), 32'h0F);
		rd(aabe_pkg::ADDR_FLAGS, 32'h20);
		run(aabe_pkg::OP_BITWISE_INVERT, 5'h2, 8'h0, 1'h0);
		rd(rf(3), 32'hF0);
		rd(aabe_pkg::ADDR_FLAGS, 32'h25);
		run(aabe_pkg::OP_SIGN_FLIP, 5'h2, 8'h0, 1'h0);
		rd(rf(3), 32'h10);
		rd(aabe_pkg::ADDR_FLAGS, 32'h01);
		run(aabe_pkg::OP_CLEAR_BITS_MASK, 5'h2, 8'h10, 1'h0);
		rd(rf(3), 32'h00);
		rd(aabe_pkg::ADDR_FLAGS, 32'h03);
		run(aabe_pkg::OP_ALL_ONES_REGISTER, 5'h2, 8'h0, 1'h0);
		rd(rf(3), 32'hFF);
		run(aabe_pkg::OP_COMPARE_IMMEDIATE, 5'h2, 8'hFF, 1'h0);
		rd(rf(3), 32'hFF);
		rd(aabe_pkg::ADDR_FLAGS, 32'h02);
		run(aabe_pkg::OP_BRANCH_FLAG_SET, 5'h0, 8'h01, 1'h0);
		rd(aabe_pkg::ADDR_PC, 32'h2E);
		rd(aabe_pkg::ADDR_STATUS, 32'h22);
		run(aabe_pkg::OP_FRACTION_PRODUCT_UNSIGNED, 5'h4, 8'h0, 1'h0);
		rd(rf(0), 32'h02);
		rd(rf(1), 32'hFC);
		rd(aabe_pkg::ADDR_FLAGS, 32'h01);
		wr(aabe_pkg::ADDR_IO, 32'h08);
		run(aabe_pkg::OP_SKIP_IO_BIT_SET, 5'h0, 8'h03, 1'h0);
		rd(aabe_pkg::ADDR_PC, 32'h31);
		wr(rf(30), 32'h34);
		wr(rf(31), 32'h12);
		run(aabe_pkg::OP_INDIRECT_JUMP, 5'h0, 8'h0, 1'h0);
		rd(aabe_pkg::ADDR_PC, 32'h1234);
		run(aabe_pkg::OP_COMPARE_SKIP_EQUAL, 5'h4, 8'h0, 1'h0);
		rd(aabe_pkg::ADDR_PC, 32'h1236);
		run(aabe_pkg::OP_WORD_ADD_IMMEDIATE, 5'h3, 8'h01, 1'h0);
		rd(rf(4), 32'h00);
		rd(rf(5), 32'h00);
		rd(aabe_pkg::ADDR_FLAGS, 32'h03);
		$display("ops test done");
	endtask : t_ops
	task wrap_up;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'h1;
		t_arith();
		t_flow();
		t_ops();
		wrap_up();
	end
	initial begin
		#200000;
		errors++;
		wrap_up();
	end
endmodule : tb_top
